/* File: bench/contact_model.sv */
// contact inputs and load current as seen from the command block
`timescale 1ns/100ps
module contact_model (
  input wire logic aclk,
  input wire logic [2:0] code,
  input wire logic [15:0] load,
  output logic preset_select_in0 = 1'b0,
  output logic preset_select_in1 = 1'b0,
  output logic preset_select_in2 = 1'b0,
  output logic [15:0] output_current = 16'h0000
);
  logic [2:0] last_q = 3'h0;
  logic [1:0] bounce_q = 2'h0;
  // a new code chatters for two cycles, so the debounce has work to do
  always_ff @(posedge aclk) begin
    last_q <= code;
    if (code != last_q) begin
      bounce_q <= 2'h2;
    end else if (bounce_q != 2'h0) begin
      bounce_q <= bounce_q - 2'h1;
    end
    {preset_select_in2, preset_select_in1, preset_select_in0} <=
      (bounce_q != 2'h0) ? ~code : code;
    output_current <= load;
  end
endmodule : contact_model

/* File: bench/testbench.sv */
// self-checking bench for the speed and voltage command block
`timescale 1ns/100ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [6:0] awaddr = 7'h00, araddr = 7'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, flash, fault, climit;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [2:0] code = 3'h0;
  logic [15:0] load = 16'h0000, cur, freq, volt, disp;
  logic in0, in1, in2;
  logic [7:0] fcode;
  int miscompares = 0;
  int cmp_count = 0;
  always #12.5 aclk = ~aclk;
  contact_model i_far (.aclk(aclk), .code(code), .load(load),
    .preset_select_in0(in0), .preset_select_in1(in1),
    .preset_select_in2(in2), .output_current(cur));
  drive_speed_voltage_command #(.OL_TICK_CYC(10), .DEBOUNCE_CYC(4),
    .RAMP_CYC(2)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .preset_select_in0(in0),
    .preset_select_in1(in1), .preset_select_in2(in2),
    .output_current(cur), .output_freq(freq), .voltage_cmd(volt),
    .display_value(disp), .display_flash(flash), .overload_fault(fault),
    .overload_fault_code(fcode), .current_limit_active(climit));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] idx, input logic [15:0] val);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask : wr
  task automatic rdr(input logic [4:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask : rdr
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for the ramp to land on a frequency, then hold a while
  task automatic settle(input logic [15:0] f);
    int n;
    n = 0;
    while (freq !== f && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    repeat (60) @(posedge aclk);
    check("output_freq", {16'h0000, freq}, {16'h0000, f});
  endtask : settle
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (80000) @(posedge aclk);
    miscompares++;
    test_done();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [4:0] idx [6] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h12};
    logic [15:0] dft [6] = '{16'h0258, 16'h05dc, 16'h03e8, 16'h0258,
                             16'h000a, 16'h0258};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdr(idx[i]);
      check("default", rd, {16'h0000, dft[i]});
    end
    rdr(5'h17);
    check("unmapped resp", {30'h0, resp}, {30'h0, drive_cmd_pkg::RESP_SLVERR});
    check("unmapped data", rd, 32'h0000_0000);
    wr(drive_cmd_pkg::IDX_CLIM, 16'h07d0);
    wr(drive_cmd_pkg::IDX_CTRL, 16'h0002);
    load <= 16'h073a;
    repeat (8) @(posedge aclk);
    check("climit high", {31'h0, climit}, 32'h0000_0001);
    load <= 16'h06a4;
    repeat (8) @(posedge aclk);
    check("climit mid", {31'h0, climit}, 32'h0000_0000);
    wr(drive_cmd_pkg::IDX_CTRL, 16'h0000);
    repeat (8) @(posedge aclk);
    check("climit low", {31'h0, climit}, 32'h0000_0001);
    load <= 16'h0000;
    wr(drive_cmd_pkg::IDX_MIN_FREQ, 16'h0064);
    for (int k = 0; k < 7; k++) begin
      wr(drive_cmd_pkg::IDX_PRESET1 + 5'(k), 16'(20 * (k + 1)));
    end
    wr(drive_cmd_pkg::IDX_CTRL, 16'h001d);
    for (int k = 1; k < 8; k++) begin
      code <= 3'(k);
      settle(16'(20 * k));
    end
    wr(drive_cmd_pkg::IDX_CTRL, 16'h0019);
    settle(16'h0078);
    check("volt", {16'h0, volt}, 32'h0000_00d2);
    check("display", {16'h0, disp}, 32'h0000_0078);
    code <= 3'h0;
    wr(drive_cmd_pkg::IDX_SPEED_REF, 16'h0032);
    settle(16'h0064);
    wr(drive_cmd_pkg::IDX_SKIP_BW, 16'h000a);
    wr(drive_cmd_pkg::IDX_SPEED_REF, 16'h007d);
    settle(16'h0078);
    wr(drive_cmd_pkg::IDX_SPEED_REF, 16'h00c8);
    settle(16'h00c8);
    wr(drive_cmd_pkg::IDX_SPEED_REF, 16'h007d);
    settle(16'h0082);
    wr(drive_cmd_pkg::IDX_SPEED_REF, 16'h0064);
    settle(16'h0064);
    wr(drive_cmd_pkg::IDX_MOTOR_OL, 16'h000a);
    load <= 16'h05dc;
    for (int n = 0; n < 8000 && fault !== 1'b1; n++) @(posedge aclk);
    check("fault", {31'h0, fault}, 32'h0000_0001);
    check("fault code", {24'h0, fcode}, 32'h0000_000f);
    load <= 16'h0000;
    wr(drive_cmd_pkg::IDX_MOTOR_OL, 16'h03e8);
    wr(drive_cmd_pkg::IDX_CTRL, 16'h0201);
    check("fault clear", {31'h0, fault}, 32'h0000_0000);
    check("code clear", {24'h0, fcode}, 32'h0000_0000);
    wr(drive_cmd_pkg::IDX_MAX_FREQ, 16'h0320);
    wstrb <= 4'h1;
    wr(drive_cmd_pkg::IDX_SCALE, 16'hfde8);
    wstrb <= 4'hf;
    rdr(drive_cmd_pkg::IDX_SCALE);
    check("low lane", rd, 32'h0000_02e8);
    wr(drive_cmd_pkg::IDX_SCALE, 16'hfde8);
    wr(drive_cmd_pkg::IDX_ACC_BOOST, 16'h0032);
    wr(drive_cmd_pkg::IDX_SPEED_REF, 16'h02bc);
    repeat (40) @(posedge aclk);
    rdr(drive_cmd_pkg::IDX_STATUS);
    check("accel status", rd, 32'h0000_0011);
    settle(16'h02bc);
    check("volt full", {16'h0, volt}, 32'h0000_03e8);
    check("display sat", {16'h0, disp}, 32'h0000_ffff);
    check("flash", {31'h0, flash}, 32'h0000_0001);
    load <= 16'h0640;
    repeat (100) @(posedge aclk);
    check("fold-back", {31'h0, freq < 16'h02bc}, 32'h0000_0001);
    check("climit fold", {31'h0, climit}, 32'h0000_0001);
    load <= 16'h0000;
    settle(16'h02bc);
    wr(drive_cmd_pkg::IDX_CTRL, 16'h0100);
    rdr(drive_cmd_pkg::IDX_SCALE);
    check("reload", rd, 32'h0000_0258);
    test_done();
  end
endmodule : testbench

/* File: common/drive_cmd_pkg.sv */
// constants, register map and defaults for the speed and voltage command block
package drive_cmd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OL_TICK_US = 1000;
  localparam int unsigned OL_TICK_CYC = CLK_HZ / 1_000_000 * OL_TICK_US;
  localparam int unsigned OL_TIME_S = 60;
  localparam int unsigned OL_TICKS = OL_TIME_S * 1_000_000 / OL_TICK_US;
  localparam int unsigned DEBOUNCE_US = 5000;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int unsigned RAMP_US = 10;
  localparam int unsigned RAMP_CYC = CLK_HZ / 1_000_000 * RAMP_US;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 7;
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_SPEED_REF = 5'h01;
  localparam logic [4:0] IDX_MIN_FREQ = 5'h02;
  localparam logic [4:0] IDX_MAX_FREQ = 5'h03;
  localparam logic [4:0] IDX_CLIM = 5'h04;
  localparam logic [4:0] IDX_MOTOR_OL = 5'h05;
  localparam logic [4:0] IDX_BASE = 5'h06;
  localparam logic [4:0] IDX_FIX_BOOST = 5'h07;
  localparam logic [4:0] IDX_ACC_BOOST = 5'h08;
  localparam logic [4:0] IDX_SLIP = 5'h09;
  localparam logic [4:0] IDX_PRESET1 = 5'h0a;
  localparam logic [4:0] IDX_PRESET6 = 5'h0f;
  localparam logic [4:0] IDX_PRESET7 = 5'h10;
  localparam logic [4:0] IDX_SKIP_BW = 5'h11;
  localparam logic [4:0] IDX_SCALE = 5'h12;
  localparam logic [4:0] IDX_OUT_FREQ = 5'h13;
  localparam logic [4:0] IDX_VOLT = 5'h14;
  localparam logic [4:0] IDX_DISP = 5'h15;
  localparam logic [4:0] IDX_STATUS = 5'h16;
  localparam int unsigned NUM_SET = 19;
  // ctrl bits
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_LINE_HIGH = 1;
  localparam int unsigned CTRL_PFN = 2;
  localparam int unsigned CTRL_DEFAULTS = 8;
  localparam int unsigned CTRL_FAULT_CLR = 9;
  // ----------------------------------------------------------------
  // limits in tenths of a unit, then the fault and response codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CLIM_CAP_HIGH = 16'h0708;
  localparam logic [15:0] CLIM_CAP_LOW = 16'h05dc;
  localparam logic [15:0] PCT_100 = 16'h03e8;
  localparam logic [15:0] PCT_OL = 16'h05dc;
  localparam logic [15:0] FULL_VOLT = 16'h03e8;
  localparam logic [31:0] DISP_FREQ_REF = 32'h0000_0258;
  localparam logic [31:0] DISP_MAX = 32'h0001_0000;
  localparam logic [15:0] SCALE_MAX = 16'hfde8;
  localparam logic [7:0] OVERLOAD_FAULT_CODE = 8'h0f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // factory defaults of the settings store
  function automatic logic [15:0] set_default(input logic [4:0] idx);
    unique case (idx)
      IDX_MAX_FREQ: set_default = 16'h0258;
      IDX_CLIM: set_default = 16'h05dc;
      IDX_MOTOR_OL: set_default = 16'h03e8;
      IDX_BASE: set_default = 16'h0258;
      IDX_FIX_BOOST: set_default = 16'h000a;
      IDX_SCALE: set_default = 16'h0258;
      default: set_default = 16'h0000;
    endcase
  endfunction : set_default
endpackage : drive_cmd_pkg

/* File: hdl/drive_speed_voltage_command.sv */
// speed reference, skip, fold-back, overload, V/Hz and display logic
`timescale 1ns/100ps
// Operation
// - current limit capped at 180% on high line, 150% on low line
// - output current above limit lowers the commanded frequency
// - once current is back under limit, ramp back to setpoint
// - overload timer, 150% for one minute scaled, trips with fault code
// - full voltage at base frequency, proportional to frequency below it
// - base frequency change takes effect only once stopped
// - below half base frequency add the fixed boost voltage
// - factory defaults load fixed boost of 1.0 percent
// - acceleration boost added while accelerating, removed at setpoint
// - slip compensation raises frequency with load
// - three preset inputs form binary code, codes 1 to 7 pick presets
// - inputs assigned another function count as open
// - presets skip the minimum clamp, limited to 0 Hz to maximum
// - skip bands enabled by nonzero bandwidth, presets 6 and 7 as edges
// - band spans skip frequency to skip plus bandwidth, no steady running
// - from below, hold at band bottom until command reaches band top
// - from above, hold at band top until command below bottom
// - presets 6 and 7 selectable as running speeds when approached from below
// - display equals scaling times frequency over 60 Hz, clamped
// - display flashes out of range when scaled value is too large
// - non-preset reference clamped between minimum and maximum
module drive_speed_voltage_command #(
  parameter int unsigned OL_TICK_CYC = drive_cmd_pkg::OL_TICK_CYC,
  parameter int unsigned DEBOUNCE_CYC = drive_cmd_pkg::DEBOUNCE_CYC,
  parameter int unsigned RAMP_CYC = drive_cmd_pkg::RAMP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [6:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic preset_select_in0,
  input wire logic preset_select_in1,
  input wire logic preset_select_in2,
  input wire logic [15:0] output_current,
  output logic [15:0] output_freq,
  output logic [15:0] voltage_cmd,
  output logic [15:0] display_value,
  output logic display_flash,
  output logic overload_fault,
  output logic [7:0] overload_fault_code,
  output logic current_limit_active
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [15:0] set_q [drive_cmd_pkg::NUM_SET];
  logic [9:0] ctrl_q;
  logic s_axi_awready_q, s_axi_bvalid_q, s_axi_arready_q, s_axi_rvalid_q;
  logic [1:0] s_axi_bresp_q, s_axi_rresp_q;
  logic [31:0] s_axi_rdata_q;
  logic [15:0] output_freq_q, voltage_cmd_q, display_value_q;
  logic wr_go, rd_go;
  logic [4:0] wr_idx, rd_idx;
  logic [31:0] status_w;
  logic [31:0] rd_val;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready_q
                 && !s_axi_bvalid_q;
  assign rd_go = s_axi_arvalid && !s_axi_arready_q && !s_axi_rvalid_q;
  assign wr_idx = s_axi_awaddr[6:2];
  assign rd_idx = s_axi_araddr[6:2];

  // address and data are taken together, so either arrival order works
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready_q <= 1'b0;
      s_axi_bvalid_q <= 1'b0;
      s_axi_bresp_q <= drive_cmd_pkg::RESP_OKAY;
    end else begin
      s_axi_awready_q <= wr_go;
      if (wr_go) begin
        s_axi_bvalid_q <= 1'b1;
        s_axi_bresp_q <= (wr_idx > drive_cmd_pkg::IDX_STATUS) ?
                         drive_cmd_pkg::RESP_SLVERR : drive_cmd_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (rd_idx == drive_cmd_pkg::IDX_CTRL) begin
      rd_val[9:0] = ctrl_q;
    end else if (rd_idx < drive_cmd_pkg::IDX_OUT_FREQ) begin
      rd_val[15:0] = set_q[rd_idx];
    end else if (rd_idx == drive_cmd_pkg::IDX_OUT_FREQ) begin
      rd_val[15:0] = output_freq_q;
    end else if (rd_idx == drive_cmd_pkg::IDX_VOLT) begin
      rd_val[15:0] = voltage_cmd_q;
    end else if (rd_idx == drive_cmd_pkg::IDX_DISP) begin
      rd_val[15:0] = display_value_q;
    end else if (rd_idx == drive_cmd_pkg::IDX_STATUS) begin
      rd_val = status_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready_q <= 1'b0;
      s_axi_rvalid_q <= 1'b0;
      s_axi_rdata_q <= 32'h0000_0000;
      s_axi_rresp_q <= drive_cmd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_q <= rd_go;
      if (rd_go) begin
        s_axi_rvalid_q <= 1'b1;
        s_axi_rdata_q <= rd_val;
        s_axi_rresp_q <= (rd_idx > drive_cmd_pkg::IDX_STATUS) ?
                         drive_cmd_pkg::RESP_SLVERR : drive_cmd_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid_q <= 1'b0;
      end
    end
  end

  // settings store; the defaults bit reloads every setting
  logic load_def;
  assign load_def = wr_go && wr_idx == drive_cmd_pkg::IDX_CTRL
                    && s_axi_wstrb[1] && s_axi_wdata[drive_cmd_pkg::CTRL_DEFAULTS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 10'h000;
    end else if (wr_go && wr_idx == drive_cmd_pkg::IDX_CTRL) begin
      if (s_axi_wstrb[0]) ctrl_q[7:0] <= s_axi_wdata[7:0];
      ctrl_q[9:8] <= 2'h0;
    end else begin
      ctrl_q[9:8] <= 2'h0;
    end
  end

  for (genvar i = 0; i < drive_cmd_pkg::NUM_SET; i++) begin : g_set
    always_ff @(posedge aclk) begin
      if (!aresetn || load_def) begin
        set_q[i] <= drive_cmd_pkg::set_default(5'(i));
      end else if (wr_go && wr_idx == 5'(i) && i != 0) begin
        if (s_axi_wstrb[0]) set_q[i][7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) set_q[i][15:8] <= s_axi_wdata[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // preset inputs, synchronise and debounce
  // ----------------------------------------------------------------
  logic [2:0] pin_w, sync1_q, sync2_q, deb_q;
  assign pin_w = {preset_select_in2, preset_select_in1, preset_select_in0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= pin_w;
      sync2_q <= sync1_q;
    end
  end

  for (genvar b = 0; b < 3; b++) begin : g_deb
    logic [31:0] cnt_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q <= 32'h0000_0000;
        deb_q[b] <= 1'b0;
      end else if (sync2_q[b] == deb_q[b]) begin
        cnt_q <= 32'h0000_0000;
      end else if (cnt_q >= DEBOUNCE_CYC - 1) begin
        cnt_q <= 32'h0000_0000;
        deb_q[b] <= sync2_q[b];
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // speed target
  // ----------------------------------------------------------------
  logic [2:0] code;
  logic [15:0] fmin, fmax, pre, ref_cl, target, skip_bw, ramp_q;
  logic [16:0] top6, top7;
  logic run, fault_q;

  assign code = deb_q & ctrl_q[drive_cmd_pkg::CTRL_PFN +: 3];
  assign fmin = set_q[drive_cmd_pkg::IDX_MIN_FREQ];
  assign fmax = set_q[drive_cmd_pkg::IDX_MAX_FREQ];
  assign skip_bw = set_q[drive_cmd_pkg::IDX_SKIP_BW];
  assign pre = set_q[drive_cmd_pkg::IDX_PRESET1 + 5'(code) - 5'h01];
  assign run = ctrl_q[drive_cmd_pkg::CTRL_RUN] && !fault_q;
  assign top6 = {1'b0, set_q[drive_cmd_pkg::IDX_PRESET6]} + {1'b0, skip_bw};
  assign top7 = {1'b0, set_q[drive_cmd_pkg::IDX_PRESET7]} + {1'b0, skip_bw};

  // hold the edge on the side the ramp is on; crossing once past it
  function automatic logic [15:0] skip(input logic [15:0] t,
                                       input logic [15:0] lo,
                                       input logic [16:0] hi,
                                       input logic [15:0] now);
    skip = t;
    if ({1'b0, t} >= {1'b0, lo} && {1'b0, t} < hi) begin
      skip = (now <= lo) ? lo : hi[15:0];
    end
  endfunction : skip

  always_comb begin
    ref_cl = set_q[drive_cmd_pkg::IDX_SPEED_REF];
    if (ref_cl < fmin) ref_cl = fmin;
    if (ref_cl > fmax) ref_cl = fmax;
    if (code != 3'h0) ref_cl = (pre > fmax) ? fmax : pre;
    if (skip_bw != 16'h0000) begin
      ref_cl = skip(ref_cl, set_q[drive_cmd_pkg::IDX_PRESET6], top6, ramp_q);
      ref_cl = skip(ref_cl, set_q[drive_cmd_pkg::IDX_PRESET7], top7, ramp_q);
    end
    target = run ? ref_cl : 16'h0000;
  end

  // ----------------------------------------------------------------
  // ramp with current fold-back
  // ----------------------------------------------------------------
  logic [15:0] clim_eff;
  logic over, accel_q;
  logic [31:0] rcnt_q;
  logic rtick;

  always_comb begin
    clim_eff = set_q[drive_cmd_pkg::IDX_CLIM];
    if (ctrl_q[drive_cmd_pkg::CTRL_LINE_HIGH]) begin
      if (clim_eff > drive_cmd_pkg::CLIM_CAP_HIGH) begin
        clim_eff = drive_cmd_pkg::CLIM_CAP_HIGH;
      end
    end else if (clim_eff > drive_cmd_pkg::CLIM_CAP_LOW) begin
      clim_eff = drive_cmd_pkg::CLIM_CAP_LOW;
    end
  end

  assign over = output_current > clim_eff;
  assign rtick = rcnt_q >= RAMP_CYC - 1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcnt_q <= 32'h0000_0000;
      ramp_q <= 16'h0000;
      accel_q <= 1'b0;
    end else begin
      rcnt_q <= rtick ? 32'h0000_0000 : rcnt_q + 32'h0000_0001;
      accel_q <= ramp_q < target && !over;
      if (rtick) begin
        if (over && ramp_q != 16'h0000) begin
          ramp_q <= ramp_q - 16'h0001;
        end else if (ramp_q < target) begin
          ramp_q <= ramp_q + 16'h0001;
        end else if (ramp_q > target) begin
          ramp_q <= ramp_q - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // overload timer, budget is the area of the excess of 150% of setting over the setting, for a minute
  // ----------------------------------------------------------------
  logic [15:0] mol;
  logic [31:0] ocnt_q, ol_acc_q, budget;
  logic otick;
  assign mol = set_q[drive_cmd_pkg::IDX_MOTOR_OL];
  assign budget = 32'(({16'h0000, mol} * 32'(drive_cmd_pkg::PCT_OL
                  - drive_cmd_pkg::PCT_100)) / 32'(drive_cmd_pkg::PCT_100)
                  * drive_cmd_pkg::OL_TICKS);
  assign otick = ocnt_q >= OL_TICK_CYC - 1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ocnt_q <= 32'h0000_0000;
      ol_acc_q <= 32'h0000_0000;
    end else begin
      ocnt_q <= otick ? 32'h0000_0000 : ocnt_q + 32'h0000_0001;
      if (otick) begin
        if (output_current > mol) begin
          ol_acc_q <= ol_acc_q + 32'(output_current - mol);
        end else if (ol_acc_q > 32'(mol - output_current)) begin
          ol_acc_q <= ol_acc_q - 32'(mol - output_current);
        end else begin
          ol_acc_q <= 32'h0000_0000;
        end
      end
    end
  end

  logic [7:0] fault_code_q;

  // a trip in the same cycle as a clear keeps the fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_q <= 1'b0;
      fault_code_q <= 8'h00;
    end else if (ol_acc_q >= budget && budget != 32'h0000_0000) begin
      fault_q <= 1'b1;
      fault_code_q <= drive_cmd_pkg::OVERLOAD_FAULT_CODE;
    end else if (wr_go && wr_idx == drive_cmd_pkg::IDX_CTRL && s_axi_wstrb[1]
                 && s_axi_wdata[drive_cmd_pkg::CTRL_FAULT_CLR]) begin
      fault_q <= 1'b0;
      fault_code_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // output frequency, voltage and display
  // ----------------------------------------------------------------
  logic [15:0] base_q, fout, vcmd;
  logic [31:0] slip_add, vlin, disp;

  // a new base frequency is taken only while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_q <= drive_cmd_pkg::set_default(drive_cmd_pkg::IDX_BASE);
    end else if (ramp_q == 16'h0000 && !run) begin
      base_q <= set_q[drive_cmd_pkg::IDX_BASE];
    end
  end

  assign slip_add = {16'h0000, set_q[drive_cmd_pkg::IDX_SLIP]}
                    * {16'h0000, output_current}
                    / {16'h0000, drive_cmd_pkg::PCT_100};

  always_comb begin
    fout = ramp_q;
    if (ramp_q != 16'h0000) begin
      fout = 16'(ramp_q + slip_add[15:0]);
    end
    vlin = {16'h0000, fout} * {16'h0000, drive_cmd_pkg::FULL_VOLT};
    if (base_q == 16'h0000 || fout >= base_q) begin
      vcmd = drive_cmd_pkg::FULL_VOLT;
    end else begin
      vcmd = 16'(vlin / {16'h0000, base_q});
    end
    if (fout < (base_q >> 1)) begin
      vcmd = 16'(vcmd + set_q[drive_cmd_pkg::IDX_FIX_BOOST]);
    end
    if (accel_q) begin
      vcmd = 16'(vcmd + set_q[drive_cmd_pkg::IDX_ACC_BOOST]);
    end
  end

  logic [15:0] scale;
  assign scale = (set_q[drive_cmd_pkg::IDX_SCALE] > drive_cmd_pkg::SCALE_MAX)
                 ? drive_cmd_pkg::SCALE_MAX : set_q[drive_cmd_pkg::IDX_SCALE];
  assign disp = {16'h0000, scale} * {16'h0000, fout}
                / drive_cmd_pkg::DISP_FREQ_REF;

  logic display_flash_q, clim_act_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_freq_q <= 16'h0000;
      voltage_cmd_q <= 16'h0000;
      display_value_q <= 16'h0000;
      display_flash_q <= 1'b0;
      clim_act_q <= 1'b0;
    end else begin
      output_freq_q <= fout;
      voltage_cmd_q <= (fout == 16'h0000) ? 16'h0000 : vcmd;
      display_flash_q <= disp > drive_cmd_pkg::DISP_MAX;
      display_value_q <= (disp > 32'h0000_ffff) ? 16'hffff : disp[15:0];
      clim_act_q <= over;
    end
  end

  assign status_w = {26'h0, display_flash_q, accel_q, clim_act_q, fault_q,
                     code != 3'h0, run};
  assign s_axi_awready = s_axi_awready_q;
  assign s_axi_wready = s_axi_awready_q;
  assign s_axi_bvalid = s_axi_bvalid_q;
  assign s_axi_bresp = s_axi_bresp_q;
  assign s_axi_arready = s_axi_arready_q;
  assign s_axi_rvalid = s_axi_rvalid_q;
  assign s_axi_rdata = s_axi_rdata_q;
  assign s_axi_rresp = s_axi_rresp_q;
  assign output_freq = output_freq_q;
  assign voltage_cmd = voltage_cmd_q;
  assign display_value = display_value_q;
  assign display_flash = display_flash_q;
  assign overload_fault = fault_q;
  assign overload_fault_code = fault_code_q;
  assign current_limit_active = clim_act_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_trip_cause;
    ol_acc_q >= budget && budget != 32'h0000_0000;
  endsequence

  a_clim_cap: assert property (clim_eff <= (ctrl_q[drive_cmd_pkg::CTRL_LINE_HIGH] ? drive_cmd_pkg::CLIM_CAP_HIGH : drive_cmd_pkg::CLIM_CAP_LOW)) else $error("current limit above cap");
  a_fold_back: assert property (rtick && over && ramp_q != 16'h0000 |=> ramp_q == $past(ramp_q) - 16'h0001) else $error("no fold-back");
  a_overload_trip: assert property (s_trip_cause |=> fault_q && overload_fault_code == drive_cmd_pkg::OVERLOAD_FAULT_CODE) else $error("no overload trip");
  a_base_defer: assert property (run |=> base_q == $past(base_q)) else $error("base changed while running");
  a_preset_range: assert property (code != 3'h0 && skip_bw == 16'h0000 && run |-> target <= fmax) else $error("preset above maximum");
  a_skip_band: assert property (skip_bw != 16'h0000 |-> !({1'b0, target} > {1'b0, set_q[drive_cmd_pkg::IDX_PRESET6]} && {1'b0, target} < top6)) else $error("target inside skip band");
  a_disp_flash: assert property (##1 display_flash_q == ($past(disp) > drive_cmd_pkg::DISP_MAX)) else $error("flash mismatch");
  a_write_resp: assert property (wr_go |=> s_axi_awready_q && s_axi_bvalid_q ##1 !s_axi_awready_q) else $error("write not answered");
endmodule : drive_speed_voltage_command
